// *** core/dco_i2c_master.sv ***
// APB-controlled two-wire bus controller for the oscillator link
`include "dco_cfg.svh"

module dco_i2c_master (
	input  wire logic        pclk,     // System clock
	input  wire logic        presetn,  // Async reset, active low
	input  wire logic        ce,       // Clock enable, freezes all state when low
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB enable
	input  wire logic        pwrite,   // APB direction
	input  wire logic [11:0] paddr,    // APB byte address
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error
	dco_i2c_if.host          link      // Two-wire bus
);
	import dco_pkg::*;

	// ==========================================================
	// APB slave
	master_state_t st_q;
	logic [11:0]   cmd_q;
	logic [7:0]    rx_q;
	logic          nack_q;
	logic [31:0]   prdata_q;
	logic          pready_q;
	logic          pslverr_q;
	logic          busy;
	logic          cmd_go;

	assign busy   = (st_q != M_IDLE);
	assign cmd_go = psel & penable & pready_q & pwrite & ~pslverr_q & (paddr == `MREG_CMD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q  <= psel & ~penable;
			pslverr_q <= 1'b0;
			if (psel && !penable) begin
				prdata_q  <= (paddr == `MREG_STAT) ? {16'h0000, rx_q, 6'h00, nack_q, busy} : 32'h0000_0000;
				// A command written while busy would tear the byte in flight
				pslverr_q <= ((paddr != `MREG_CMD) && (paddr != `MREG_STAT)) || (pwrite && paddr == `MREG_CMD && busy);
			end
		end
	end

	// ==========================================================
	// Bit engine
	logic [1:0]  sda_sync_q;
	logic [3:0]  qc_q;
	logic [1:0]  ph_q;
	logic [3:0]  bit_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic        tick;

	assign tick = (qc_q == `SCL_QTR - 4'h1);

	// Pull-down enable for bit b of the current command
	function automatic logic drv(input logic [11:0] c, input logic [3:0] b);
		if (b < `BYTE_BITS)
			drv = c[`CMD_READ_BIT] ? 1'b0 : ~c[3'(4'h7 - b)];
		else
			drv = c[`CMD_READ_BIT] ? ~c[`CMD_ACK_BIT] : 1'b0;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sda_sync_q <= 2'h3;
		else if (ce)
			sda_sync_q <= {sda_sync_q[0], link.sda};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= M_IDLE;
			cmd_q    <= 12'h000;
			rx_q     <= 8'h00;
			nack_q   <= 1'b0;
			qc_q     <= 4'h0;
			ph_q     <= 2'h0;
			bit_q    <= 4'h0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (ce) begin
			qc_q <= (busy && !tick) ? qc_q + 4'h1 : 4'h0;
			if (busy && tick)
				ph_q <= ph_q + 2'h1;
			case (st_q)
				M_IDLE: begin
					if (cmd_go) begin
						cmd_q <= pwdata[11:0];
						ph_q  <= 2'h0;
						bit_q <= 4'h0;
						if (pwdata[`CMD_START_BIT]) begin
							st_q     <= M_START;
							sda_oe_q <= 1'b0;
						end else begin
							st_q     <= M_BITS;
							sda_oe_q <= drv(pwdata[11:0], 4'h0);
						end
					end
				end
				M_START: begin
					// Release SDA, raise SCL, pull SDA low, then SCL low
					if (tick) begin
						case (ph_q)
							2'h0: scl_oe_q <= 1'b0;
							2'h1: sda_oe_q <= 1'b1;
							2'h2: scl_oe_q <= 1'b1;
							default: begin
								st_q     <= M_BITS;
								bit_q    <= 4'h0;
								sda_oe_q <= drv(cmd_q, 4'h0);
							end
						endcase
					end
				end
				M_BITS: begin
					if (tick) begin
						case (ph_q)
							2'h0: scl_oe_q <= 1'b0;
							2'h1: ;
							2'h2: begin
								if (bit_q < `BYTE_BITS)
									rx_q <= {rx_q[6:0], sda_sync_q[1]};
								else
									nack_q <= sda_sync_q[1];
								scl_oe_q <= 1'b1;
							end
							default: begin
								if (bit_q == `BYTE_BITS) begin
									if (cmd_q[`CMD_STOP_BIT]) begin
										st_q     <= M_STOP;
										sda_oe_q <= 1'b1;
									end else begin
										st_q     <= M_IDLE;
										sda_oe_q <= 1'b0;
									end
								end else begin
									bit_q    <= bit_q + 4'h1;
									sda_oe_q <= drv(cmd_q, bit_q + 4'h1);
								end
							end
						endcase
					end
				end
				M_STOP: begin
					if (tick) begin
						case (ph_q)
							2'h0: scl_oe_q <= 1'b0;
							2'h1: sda_oe_q <= 1'b0;
							2'h2: ;
							default: st_q <= M_IDLE;
						endcase
					end
				end
				default: st_q <= M_IDLE;
			endcase
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign link.scl_oe_m  = scl_oe_q;
	assign link.scl_out_m = 1'b0;
	assign link.sda_oe_m  = sda_oe_q;
	assign link.sda_out_m = 1'b0;
endmodule

// *** core/dco_i2c_slave.sv ***
// Two-wire register slave of the tuned oscillator with pull timing
//
// Our own choice: the APB interface to the bus controller.
`include "dco_cfg.svh"

module dco_i2c_slave #(
	parameter int unsigned  DELAY_CYC = `PULL_DELAY_CYC,
	parameter logic [6:0]   OWN_ADDR  = `DEV_ADDR_DEF,  // Arbitrary default, set per board
	parameter dco_pkg::range_t RANGE_DEF = `RANGE_DEF  // Arbitrary factory code
) (
	input  wire logic               pclk,          // System clock
	input  wire logic               presetn,       // Async reset, active low
	input  wire logic               ce,            // Clock enable, freezes all state when low
	dco_i2c_if.device               link,          // Two-wire bus
	output dco_pkg::pull_word_t     pull_value,    // Applied pull value, two's complement
	output dco_pkg::range_t         pull_range,    // Pull range code
	output dco_pkg::span_t          pull_span,     // Pull span, hundredths of a ppm
	output logic                    out_enable,    // Output driver enable bit
	output logic                    pull_start,    // One-cycle pulse when a new pull begins
	output logic                    pull_settled   // High once the pull has settled
);
	import dco_pkg::*;

	localparam int unsigned SETTLE_CYC = `PULL_SETTLE_CYC;

	// ==========================================================
	// Pin synchronisers and bus conditions
	logic [2:0] scl_sync_q;
	logic [2:0] sda_sync_q;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
		end else if (ce) begin
			scl_sync_q <= {scl_sync_q[1:0], link.scl};
			sda_sync_q <= {sda_sync_q[1:0], link.sda};
		end
	end

	assign scl_s    = scl_sync_q[1];
	assign sda_s    = sda_sync_q[1];
	assign scl_rise = scl_s & ~scl_sync_q[2];
	assign scl_fall = ~scl_s & scl_sync_q[2];
	// conditions only with SCL high on both samples
	assign start_c  = scl_s & scl_sync_q[2] & sda_sync_q[2] & ~sda_s;
	assign stop_c   = scl_s & scl_sync_q[2] & ~sda_sync_q[2] & sda_s;

	// ==========================================================
	// Register storage
	logic [15:0]          lower_q;
	logic [10:0]          upper_q;
	range_t               range_q;
	logic                 wr_stb_q;
	logic [7:0]           wr_addr_q;
	logic [15:0]          wr_data_q;
	logic [7:0]           ptr_q;
	logic [7:0]           ptr_nx;
	logic [15:0]          rd_cur;
	logic [15:0]          rd_nxt;

	// unused bits and unmapped pointers read zero
	function automatic logic [15:0] rd_word(input logic [7:0] a);
		case (a)
			`REG_LOWER: rd_word = lower_q;
			`REG_UPPER: rd_word = {5'h00, upper_q};
			`REG_RANGE: rd_word = {12'h000, range_q};
			default:    rd_word = 16'h0000;
		endcase
	endfunction

	// eight-bit sum wraps from 255 to 0
	assign ptr_nx = ptr_q + 8'h01;
	assign rd_cur = rd_word(ptr_q);
	assign rd_nxt = rd_word(ptr_nx);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_q <= 16'h0000;
			upper_q <= 11'h000;
			range_q <= RANGE_DEF;
		end else if (ce && wr_stb_q) begin
			case (wr_addr_q)
				`REG_LOWER: lower_q <= wr_data_q;
				`REG_UPPER: upper_q <= wr_data_q[`UPPER_BITS-1:0];
				// only the low four bits are stored
				`REG_RANGE: range_q <= wr_data_q[3:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Byte engine
	slave_state_t st_q;
	byte_kind_t   kind_q;
	logic [3:0]   cnt_q;
	logic [7:0]   rx_q;
	logic [7:0]   hi_q;
	logic [15:0]  txs_q;
	logic         tx_lo_q;
	logic         rw_q;
	logic         mnack_q;
	logic         sda_oe_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= S_IDLE;
			kind_q    <= K_ADDR;
			cnt_q     <= 4'h0;
			rx_q      <= 8'h00;
			hi_q      <= 8'h00;
			txs_q     <= 16'h0000;
			tx_lo_q   <= 1'b0;
			rw_q      <= 1'b0;
			mnack_q   <= 1'b0;
			sda_oe_q  <= 1'b0;
			ptr_q     <= 8'h00;
			wr_stb_q  <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 16'h0000;
		end else if (ce) begin
			wr_stb_q <= 1'b0;
			// a repeated start restarts from any state
			if (start_c) begin
				st_q     <= S_RX;
				kind_q   <= K_ADDR;
				cnt_q    <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (stop_c) begin
				st_q     <= S_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (st_q)
					S_RX: begin
						// shift in MSB first on SCL rise
						if (scl_rise) begin
							rx_q  <= {rx_q[6:0], sda_s};
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == `BYTE_BITS) begin
							cnt_q <= 4'h0;
							// withhold ack only for a foreign address
							if (kind_q != K_ADDR || rx_q[7:1] == OWN_ADDR) begin
								// hold SDA low through the ninth pulse
								sda_oe_q <= 1'b1;
								st_q     <= S_ACK;
								if (kind_q == K_ADDR)
									rw_q <= rx_q[0];
							end else begin
								st_q <= S_WAIT;
							end
						end
					end
					S_ACK: begin
						if (scl_fall) begin
							sda_oe_q <= 1'b0;
							st_q     <= S_RX;
							case (kind_q)
								K_ADDR: begin
									if (rw_q) begin
										// read begins at the current pointer
										txs_q    <= rd_cur;
										sda_oe_q <= ~rd_cur[15];
										tx_lo_q  <= 1'b0;
										st_q     <= S_TX;
									end else begin
										kind_q <= K_PTR;
									end
								end
								// first write byte loads the pointer
								K_PTR: begin
									ptr_q  <= rx_q;
									kind_q <= K_HI;
								end
								K_HI: begin
									hi_q   <= rx_q;
									kind_q <= K_LO;
								end
								default: begin
									// commit once the low byte is acked
									wr_stb_q  <= 1'b1;
									wr_addr_q <= ptr_q;
									wr_data_q <= {hi_q, rx_q};
									ptr_q     <= ptr_nx;
									kind_q    <= K_HI;
								end
							endcase
						end
					end
					S_TX: begin
						if (scl_rise) begin
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall) begin
							// SDA changes only just after SCL falls
							if (cnt_q == `BYTE_BITS) begin
								cnt_q    <= 4'h0;
								sda_oe_q <= 1'b0;
								st_q     <= S_MACK;
								// One more shift so the low byte's top bit leads
								txs_q    <= {txs_q[14:0], 1'b0};
							end else begin
								sda_oe_q <= ~txs_q[14];
								txs_q    <= {txs_q[14:0], 1'b0};
							end
						end
					end
					S_MACK: begin
						if (scl_rise) begin
							mnack_q <= sda_s;
						end else if (scl_fall) begin
							if (tx_lo_q)
								ptr_q <= ptr_nx;
							// master ack ends the read, SDA stays released
							if (!mnack_q) begin
								st_q <= S_WAIT;
							end else begin
								// nack makes the next byte go out
								st_q    <= S_TX;
								tx_lo_q <= ~tx_lo_q;
								if (tx_lo_q) begin
									txs_q    <= rd_nxt;
									sda_oe_q <= ~rd_nxt[15];
								end else begin
									sda_oe_q <= ~txs_q[15];
								end
							end
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Pull timing: the upper word starts the change
	pull_word_t staged_q;
	pull_word_t pull_q;
	logic [15:0] dcnt_q;
	logic [15:0] scnt_q;
	logic        pend_q;
	logic        settling_q;
	logic        start_q;
	logic        settled_q;
	span_t       span_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			staged_q   <= '0;
			pull_q     <= '0;
			dcnt_q     <= 16'h0000;
			scnt_q     <= 16'h0000;
			pend_q     <= 1'b0;
			settling_q <= 1'b0;
			start_q    <= 1'b0;
			settled_q  <= 1'b1;
		end else if (ce) begin
			start_q <= 1'b0;
			// only an upper word write stages a new value
			if (wr_stb_q && wr_addr_q == `REG_UPPER) begin
				// upper ten bits over the lower word
				staged_q   <= {wr_data_q[9:0], lower_q};
				dcnt_q     <= 16'(DELAY_CYC - 1);
				pend_q     <= 1'b1;
				settling_q <= 1'b0;
				settled_q  <= 1'b0;
			end else if (pend_q) begin
				// typical delay, below the longest allowed
				if (dcnt_q == 16'h0000) begin
					pull_q     <= staged_q;
					start_q    <= 1'b1;
					pend_q     <= 1'b0;
					settling_q <= 1'b1;
					scnt_q     <= 16'(SETTLE_CYC - 1);
				end else begin
					dcnt_q <= dcnt_q - 16'h0001;
				end
			end else if (settling_q) begin
				// settled flag rises within the settle time
				if (scnt_q == 16'h0000) begin
					settling_q <= 1'b0;
					settled_q  <= 1'b1;
				end else begin
					scnt_q <= scnt_q - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			span_q <= '0;
		else if (ce)
			span_q <= span_of(range_q);
	end

	assign pull_value     = pull_q;
	assign pull_range     = range_q;
	assign pull_span      = span_q;
	assign out_enable     = upper_q[`UPPER_OE_BIT];
	assign pull_start     = start_q;
	assign pull_settled   = settled_q;
	// the slave only ever drives SDA, never SCL
	assign link.sda_oe_s  = sda_oe_q;
	assign link.sda_out_s = 1'b0;
endmodule

// *** inc/dco_cfg.svh ***
// Constants shared by both ends of the oscillator tuning link
`ifndef DCO_CFG_SVH
`define DCO_CFG_SVH

// ==========================================================
// Register map of the oscillator (pointer values)
`define REG_LOWER      8'h00
`define REG_UPPER      8'h01
`define REG_RANGE      8'h02

// ==========================================================
// Field positions and reset values
`define UPPER_BITS     11
`define UPPER_OE_BIT   10
`define RANGE_DEF      4'h7
`define DEV_ADDR_DEF   7'h62
`define BYTE_BITS      4'h8

// ==========================================================
// Timing, pclk runs at 40 MHz
`define CLK_PERIOD_NS  25
`define PULL_DELAY_NS  103000
`define PULL_DELAY_MAX_NS 140000
`define PULL_SETTLE_NS 20000
`define PULL_DELAY_CYC (`PULL_DELAY_NS / `CLK_PERIOD_NS)
`define PULL_SETTLE_CYC (`PULL_SETTLE_NS / `CLK_PERIOD_NS)
// Quarter of an SCL bit: 10 cycles gives a 1 us bit, within 1 Mbit/s
`define SCL_QTR        4'hA

// ==========================================================
// Controller registers on APB
`define MREG_CMD       12'h000
`define MREG_STAT      12'h004
`define CMD_START_BIT  8
`define CMD_STOP_BIT   9
`define CMD_READ_BIT   10
`define CMD_ACK_BIT    11

`endif

// *** inc/dco_i2c_if.sv ***
// Two-wire link between the bus controller and the oscillator slave
interface dco_i2c_if;
	logic scl_oe_m;
	logic scl_out_m;
	logic sda_oe_m;
	logic sda_out_m;
	logic sda_oe_s;
	logic sda_out_s;
	logic scl;
	logic sda;

	// ==========================================================
	// Open-drain lines with pull-ups: any enabled driver pulls low
	assign scl = ~(scl_oe_m & ~scl_out_m);
	assign sda = ~((sda_oe_m & ~sda_out_m) | (sda_oe_s & ~sda_out_s));

	modport device (input scl, input sda, output sda_oe_s, output sda_out_s);
	modport host   (input scl, input sda, output scl_oe_m, output scl_out_m, output sda_oe_m, output sda_out_m);
endinterface

// *** inc/dco_pkg.sv ***
// Types shared by both ends of the oscillator tuning link
package dco_pkg;
	typedef logic [25:0] pull_word_t;
	typedef logic [3:0]  range_t;
	typedef logic [18:0] span_t;

	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_RX   = 6'b000010,
		S_ACK  = 6'b000100,
		S_TX   = 6'b001000,
		S_MACK = 6'b010000,
		S_WAIT = 6'b100000
	} slave_state_t;

	typedef enum logic [3:0] {
		M_IDLE  = 4'b0001,
		M_START = 4'b0010,
		M_BITS  = 4'b0100,
		M_STOP  = 4'b1000
	} master_state_t;

	typedef enum logic [1:0] {
		K_ADDR = 2'h0,
		K_PTR  = 2'h1,
		K_HI   = 2'h2,
		K_LO   = 2'h3
	} byte_kind_t;

	// Pull span in hundredths of a ppm, ascending with the code
	function automatic span_t span_of(input range_t code);
		case (code)
			4'h0: span_of = 19'h00271;
			4'h1: span_of = 19'h003E8;
			4'h2: span_of = 19'h004E2;
			4'h3: span_of = 19'h009C4;
			4'h4: span_of = 19'h01388;
			4'h5: span_of = 19'h01F40;
			4'h6: span_of = 19'h02710;
			4'h7: span_of = 19'h030D4;
			4'h8: span_of = 19'h03A98;
			4'h9: span_of = 19'h04E20;
			4'hA: span_of = 19'h09C40;
			4'hB: span_of = 19'h0EA60;
			4'hC: span_of = 19'h13880;
			4'hD: span_of = 19'h1D4C0;
			4'hE: span_of = 19'h27100;
			default: span_of = 19'h4E200;
		endcase
	endfunction
endpackage

// *** tb/dco_i2c_chk.sv ***
// Wire-level protocol checker for the oscillator tuning link
module dco_i2c_chk #(
	parameter logic [6:0] OWN_ADDR = 7'h3A  // Slave bus address
) (
	input wire logic pclk,     // System clock
	input wire logic presetn,  // Async reset, active low
	input wire logic scl,      // Resolved clock line
	input wire logic sda,      // Resolved data line
	input wire logic sda_oe_s  // Slave pulls data low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bitn_q;
	logic [7:0] sh_q;
	logic       first_q;
	logic       rd_q;
	logic       hit_q;
	logic       rise;
	logic       start;

	assign rise  = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ====
	// Bit and byte position, seen on the raw lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bitn_q <= 4'h0;
			sh_q <= 8'h00;
			first_q <= 1'b0;
			rd_q <= 1'b0;
			hit_q <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				bitn_q <= 4'h0;
				first_q <= 1'b1;
			end else if (rise && bitn_q == 4'h8) begin
				bitn_q <= 4'h0;
				first_q <= 1'b0;
				if (first_q)
					hit_q <= sda_oe_s;
			end else if (rise) begin
				bitn_q <= bitn_q + 4'h1;
				sh_q <= {sh_q[6:0], sda};
				if (first_q && bitn_q == 4'h7)
					rd_q <= sda;
			end
		end
	end

	// ====
	// Assertions
	AST_ADDR_ACK: assert property (rise && first_q && bitn_q == 4'h8 |-> sda_oe_s == (sh_q[7:1] == OWN_ADDR))
		else $error("address acknowledge wrong");
	AST_WR_ACK: assert property (rise && !first_q && hit_q && !rd_q && bitn_q == 4'h8 |-> sda_oe_s && !sda)
		else $error("written byte not acknowledged");
	AST_RD_RELEASE: assert property (rise && !first_q && hit_q && rd_q && bitn_q == 4'h8 |-> !sda_oe_s)
		else $error("slave holds data in master ack slot");
	AST_SILENT: assert property (!first_q && !hit_q |-> !sda_oe_s)
		else $error("unaddressed slave drives data");
	AST_HOLD_HIGH: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
		else $error("slave data changed with clock high");
	AST_CHANGE_LATE: assert property ($changed(sda_oe_s) |-> !scl && !$past(scl) && !$past(scl, 2))
		else $error("slave data changed too near clock edge");
	AST_LOW_HELD: assert property (rise && sda_oe_s |-> (sda_oe_s && !sda) [*8])
		else $error("driven low level not held");
	AST_SCL_HIGH: assert property (rise |-> scl [*8])
		else $error("clock high phase too short");

	cover property (rise && first_q && bitn_q == 4'h8 && !sda_oe_s);
	cover property (rise && rd_q && !first_q && bitn_q == 4'h8 && sda);
	cover property (start && !first_q);
endmodule

// *** tb/dco_i2c_register_slave_tb.sv ***
// Self-checking bench for both ends of the oscillator tuning link
`include "dco_cfg.svh"

module dco_i2c_register_slave_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dco_pkg::*;

	localparam int          DLY  = 20;
	localparam logic [6:0]  ADDR = 7'h3A;  // Arbitrary bus address
	localparam range_t      RDEF = 4'h9;   // Arbitrary factory code
	localparam logic [11:0] P    = 12'h200;
	localparam logic [11:0] RD   = 12'h400;
	localparam logic [11:0] NK   = 12'h800;
	localparam logic [11:0] AW   = {4'h1, ADDR, 1'b0};
	localparam logic [11:0] AR   = {4'h1, ADDR, 1'b1};
	localparam span_t SPAN [16] = '{19'h271, 19'h3E8, 19'h4E2, 19'h9C4, 19'h1388, 19'h1F40, 19'h2710, 19'h30D4,
		19'h3A98, 19'h4E20, 19'h9C40, 19'hEA60, 19'h13880, 19'h1D4C0, 19'h27100, 19'h4E200};

	logic        pclk;
	logic        presetn;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	pull_word_t  pull_value;
	range_t      pull_range;
	span_t       pull_span;
	logic        out_enable;
	logic        pull_start;
	logic        pull_settled;
	logic        set_q = 1'b1;
	int          fails = 0;
	int          checked = 0;
	int          cyc = 0;
	int          starts = 0;
	int          t_fall = 0;
	int          t_start = 0;
	int          t_rise = 0;

	dco_i2c_if link_if ();
	dco_i2c_master dco_i2c_master_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(link_if.host));
	dco_i2c_slave #(.DELAY_CYC(DLY), .OWN_ADDR(ADDR), .RANGE_DEF(RDEF)) dco_i2c_slave_inst (.pclk(pclk),
		.presetn(presetn), .ce(ce), .link(link_if.device), .pull_value(pull_value), .pull_range(pull_range),
		.pull_span(pull_span), .out_enable(out_enable), .pull_start(pull_start), .pull_settled(pull_settled));
	dco_i2c_chk #(.OWN_ADDR(ADDR)) dco_i2c_chk_inst (.pclk(pclk), .presetn(presetn), .scl(link_if.scl),
		.sda(link_if.sda), .sda_oe_s(link_if.sda_oe_s));

	// ====
	// Clock, timeout and pull timing monitor
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		set_q <= pull_settled;
		if (pull_start === 1'b1) begin
			starts <= starts + 1;
			t_start <= cyc;
		end
		if (set_q === 1'b1 && pull_settled === 1'b0)
			t_fall <= cyc;
		if (set_q === 1'b0 && pull_settled === 1'b1)
			t_rise <= cyc;
		if (cyc == 95000) begin
			fails++;
			$display("unexpected at %0t: run timed out", $time);
			test_done();
		end
	end

	// ====
	// Shared tasks
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			fails++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One bus command, then wait until the controller is idle
	task automatic bus(input logic [11:0] c, output logic [7:0] rx, output logic nk);
		logic [31:0] r;
		logic        e;
		apb(1'b1, `MREG_CMD, {20'h0, c}, r, e);
		do
			apb(1'b0, `MREG_STAT, 32'h0, r, e);
		while (r[0] !== 1'b0);
		rx = r[15:8];
		nk = r[1];
	endtask

	task automatic wr(input logic [7:0] p, input logic [15:0] v);
		logic [7:0] rx;
		logic       nk;
		bus(AW, rx, nk);
		chk(nk === 1'b0, "address nack");
		bus({4'h0, p}, rx, nk);
		bus({4'h0, v[15:8]}, rx, nk);
		bus({4'h2, v[7:0]}, rx, nk);
		chk(nk === 1'b0, "data nack");
	endtask

	// Pointer write, then a repeated start into the read
	task automatic rd(input logic [7:0] p, output logic [15:0] v);
		logic nk;
		bus(AW, v[7:0], nk);
		bus({4'h0, p}, v[7:0], nk);
		bus(AR, v[7:0], nk);
		bus(RD | NK, v[15:8], nk);
		bus(RD | P, v[7:0], nk);
	endtask

	// ====
	// Scenarios
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		logic [15:0] v;
		logic        nk;
		repeat (2) @(posedge pclk);
		chk(pull_value === 26'h0 && out_enable === 1'b0 && pull_settled === 1'b1, "reset outputs");
		chk(pull_range === RDEF && pull_span === SPAN[RDEF], "default range");
		chk(link_if.scl === 1'b1 && link_if.sda === 1'b1, "bus not idle");
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk(e === 1'b1 && r === 32'h0, "unmapped address");
		bus(AR, v[7:0], nk);
		bus(RD | NK, v[15:8], nk);
		bus(RD | P, v[7:0], nk);
		chk(v === 16'h0000, "read at reset pointer");
	endtask

	task automatic t_range();
		logic [15:0] v;
		for (int c = 0; c < 16; c++) begin
			wr(8'h02, {8'hA5, 4'hC, 4'(c)});
			chk(pull_range === 4'(c) && pull_span === SPAN[c], "range code");
		end
		rd(8'h02, v);
		chk(v === 16'h000F, "range upper bits");
	endtask

	task automatic t_pull();
		logic [7:0]  rx;
		logic        nk;
		logic [15:0] v;
		bus(AW, rx, nk);
		bus(12'h000, rx, nk);
		bus(12'h012, rx, nk);
		bus(12'h034, rx, nk);
		bus(12'h007, rx, nk);
		repeat (DLY + 40) @(posedge pclk);
		chk(pull_value === 26'h0 && starts === 0, "pull applied early");
		bus(12'h2AB, rx, nk);
		repeat (DLY + 900) @(posedge pclk);
		chk(starts === 1 && pull_value === {10'h3AB, 16'h1234} && out_enable === 1'b1, "pull value");
		chk(t_start - t_fall >= DLY - 1 && t_start - t_fall <= DLY + 2, "pull delay");
		chk(t_rise - t_start >= 799 && t_rise - t_start <= 801, "settle time");
		bus(AW, rx, nk);
		bus(12'h001, rx, nk);
		bus(12'h255, rx, nk);
		rd(8'h01, v);
		chk(v === 16'h07AB && starts === 1, "lone byte written");
	endtask

	task automatic t_wrap();
		logic [7:0]  rx;
		logic        nk;
		logic [15:0] v;
		bus(AW, rx, nk);
		bus(12'h0FF, rx, nk);
		bus(12'h0C3, rx, nk);
		bus(12'h03C, rx, nk);
		bus(12'h05A, rx, nk);
		bus(12'h25A, rx, nk);
		bus(AR, rx, nk);
		bus(RD | NK, v[15:8], nk);
		bus(RD | P, v[7:0], nk);
		chk(v === 16'h07AB, "read from pointer");
		bus(AW, rx, nk);
		bus(12'h000, rx, nk);
		bus(AR, rx, nk);
		bus(RD | NK, v[15:8], nk);
		bus(RD | NK, v[7:0], nk);
		chk(v === 16'h5A5A, "wrapped write");
		bus(RD | P, rx, nk);
		chk(rx === 8'h07, "byte after nack");
	endtask

	task automatic t_foreign();
		logic [7:0] rx;
		logic       nk;
		bus({4'h1, ADDR ^ 7'h01, 1'b0}, rx, nk);
		chk(nk === 1'b1, "foreign address ack");
		bus(12'h2FF, rx, nk);
		chk(nk === 1'b1 && pull_range === 4'hF, "foreign write");
	endtask

	task automatic test_done();
		if (fails == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_range();
		t_pull();
		t_wrap();
		t_foreign();
		test_done();
	end
endmodule
